// >>> pmsc_core.sv
// polygon motor speed control core: phase compare, drive state, lock
// assumes all pins synchronous to clock_in; analog levels pre-quantised
// Contract
// - compare reference rising edge with feedback rising edge for phase error
// - crystal mode servos feedback to crystal rate over divisor
// - external mode servos feedback frequency to external reference
// - slowing during speed change or pull-in uses low-side short braking
// - stop command turns all outputs off, motor coasts
// - external mode without reference pulses stays braked despite start
// - start with Hall signals absent cuts output current
// - lock detect from phase error only, not speed error
// - lock assertion delayed 0.35 s per microfarad of mask capacitor
// - open mask pin gives undelayed lock report
// - peak current limited when sense voltage reaches threshold
// - shutoff pin pulled low shuts off all drive current
// - second divisor pin is three-level, open reads middle
`timescale 1ns/10ps
module pmsc_core
  import pmsc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // host controls
  input wire pmsc_pkg::pmsc_ctrl_type ctrl_in,
  // crystal enable and motor side sensing
  input wire logic crystal_tick_in,
  input wire logic speed_feedback_pulse_in,
  input wire logic hall_edge_in,
  input wire logic sense_at_threshold_in,
  // drive decision and status
  output pmsc_pkg::pmsc_drive_type drive_out,
  output logic lock_detect_out,
  output logic [15:0] phase_error_out
);
  import pmsc_pkg::*;

  localparam logic [15:0] LOCK_WIN = `PMSC_LOCK_WIN;
  localparam logic [31:0] HALL_TMO = `PMSC_HALL_TMO_CYC;
  localparam logic [31:0] REF_TMO = `PMSC_REF_TMO_CYC;
  localparam logic [31:0] MASK_STEP = `PMSC_MASK_CYC_PER_STEP;

  typedef struct packed {
    logic fb_prev;
    logic ref_seen;
    logic fb_seen;
    logic [15:0] phase_cnt;
    logic [15:0] phase_err;
    logic lead;
    logic phase_ok;
    logic [31:0] hall_idle;
    logic [31:0] ref_idle;
    logic [47:0] mask_cnt;
    logic lock;
    pmsc_drive_type drive;
  } pmsc_core_state_type;
  pmsc_core_state_type s_q, s_d;

  logic ext_mode;
  logic [15:0] divisor;
  logic ref_pulse;
  logic fb_rise;

  // divisor select from pin pair, low/high combinations only
  function automatic logic [15:0] pick_divisor(input logic a,
                                               input pmsc_level_type b);
    logic hi;
    hi = (b == PMSC_LVL_HIGH);
    case ({hi, a})
      2'h0: pick_divisor = `PMSC_DIV_LL;
      2'h1: pick_divisor = `PMSC_DIV_LH;
      2'h2: pick_divisor = `PMSC_DIV_HL;
      default: pick_divisor = `PMSC_DIV_HH;
    endcase
  endfunction

  // mask length in cycles for a capacitor in 0.01 uF steps; 48 bits so
  // even the largest capacitor code cannot wrap the product
  function automatic logic [47:0] mask_limit(input logic [15:0] cap);
    mask_limit = {16'h0000, MASK_STEP} * {32'h00000000, cap};
  endfunction

  // middle level of the second pin selects the external reference
  assign ext_mode = (ctrl_in.divisor_sel_b == PMSC_LVL_MID);
  assign divisor = pick_divisor(ctrl_in.divisor_sel_a_or_ext_ref,
                                ctrl_in.divisor_sel_b);
  assign fb_rise = speed_feedback_pulse_in & ~s_q.fb_prev;

  pmsc_ref_gen u_ref (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .crystal_tick_in(crystal_tick_in),
    .ext_mode_in(ext_mode),
    .ext_ref_in(ctrl_in.divisor_sel_a_or_ext_ref),
    .divisor_in(divisor),
    .ref_pulse_out(ref_pulse)
  );

  // phase compare, supervision and drive decision
  always_comb begin
    s_d = s_q;
    s_d.fb_prev = speed_feedback_pulse_in;
    // phase error: cycles between the two rising edges, sign in lead
    if (ref_pulse && fb_rise) begin
      s_d.phase_err = 16'h0000;
      s_d.phase_cnt = 16'h0000;
      s_d.ref_seen = 1'b0;
      s_d.fb_seen = 1'b0;
      s_d.phase_ok = 1'b1;
    end else if (ref_pulse) begin
      if (s_q.fb_seen) begin
        s_d.phase_err = s_q.phase_cnt; // feedback led: too fast
        s_d.lead = 1'b1;
        s_d.phase_ok = (s_q.phase_cnt <= LOCK_WIN);
        s_d.fb_seen = 1'b0;
        s_d.phase_cnt = 16'h0000;
      end else begin
        s_d.ref_seen = 1'b1;
        s_d.phase_cnt = 16'h0000;
      end
    end else if (fb_rise) begin
      if (s_q.ref_seen) begin
        s_d.phase_err = s_q.phase_cnt; // feedback lagged: too slow
        s_d.lead = 1'b0;
        s_d.phase_ok = (s_q.phase_cnt <= LOCK_WIN);
        s_d.ref_seen = 1'b0;
        s_d.phase_cnt = 16'h0000;
      end else begin
        s_d.fb_seen = 1'b1;
        s_d.phase_cnt = 16'h0000;
      end
    end else if ((s_q.ref_seen || s_q.fb_seen) &&
                 s_q.phase_cnt != 16'hFFFF) begin
      s_d.phase_cnt = s_q.phase_cnt + 16'h0001;
    end else if (s_q.phase_cnt == 16'hFFFF) begin
      s_d.phase_ok = 1'b0; // saturated error is never lock
    end
    // absence timers; idle saturates
    if (hall_edge_in) begin
      s_d.hall_idle = 32'h00000000;
    end else if (s_q.hall_idle < HALL_TMO) begin
      s_d.hall_idle = s_q.hall_idle + 32'h00000001;
    end
    if (ref_pulse || !ext_mode) begin
      s_d.ref_idle = 32'h00000000;
    end else if (s_q.ref_idle < REF_TMO) begin
      s_d.ref_idle = s_q.ref_idle + 32'h00000001;
    end
    // lock mask: phase lock must hold for the mask time
    if (!s_q.phase_ok || s_q.drive.state != PMSC_DRIVE) begin
      s_d.mask_cnt = 48'h000000000000;
      s_d.lock = 1'b0;
    end else if (ctrl_in.mask_cap_open) begin
      s_d.lock = 1'b1;
    end else if (s_q.mask_cnt >=
                 mask_limit(ctrl_in.mask_cap_centi_uf)) begin
      s_d.lock = 1'b1;
    end else begin
      s_d.mask_cnt = s_q.mask_cnt + 48'h000000000001;
    end
    // drive state, priority: stop, shutoff, hall loss, no ext ref, servo
    s_d.drive.low_side_all = 1'b0;
    s_d.drive.limit_active = sense_at_threshold_in;
    if (ctrl_in.start_n) begin
      s_d.drive.state = PMSC_OFF;
      s_d.drive.drive_level = 16'h0000;
    end else if (!ctrl_in.loop_comp_shutoff_pin_n) begin
      s_d.drive.state = PMSC_CUT;
      s_d.drive.drive_level = 16'h0000;
    end else if (s_q.hall_idle >= HALL_TMO) begin
      s_d.drive.state = PMSC_CUT;
      s_d.drive.drive_level = 16'h0000;
    end else if (ext_mode && s_q.ref_idle >= REF_TMO) begin
      s_d.drive.state = PMSC_BRAKE;
      s_d.drive.drive_level = 16'h0000;
      s_d.drive.low_side_all = 1'b1;
    end else if (s_q.lead && s_q.phase_err != 16'h0000) begin
      s_d.drive.state = PMSC_BRAKE;
      s_d.drive.drive_level = 16'h0000;
      s_d.drive.low_side_all = 1'b1;
    end else begin
      s_d.drive.state = PMSC_DRIVE;
      // more lag asks for more current, clipped by the limiter
      if (sense_at_threshold_in) begin
        s_d.drive.drive_level = s_q.drive.drive_level;
      end else begin
        s_d.drive.drive_level = s_q.phase_err;
      end
    end
  end

  // single state register; reset holds outputs off and unlocked
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign drive_out = s_q.drive;
  assign lock_detect_out = s_q.lock;
  assign phase_error_out = s_q.phase_err;

  // stop forces outputs off on the next edge
  a_stop_coasts: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    ctrl_in.start_n |=> drive_out.state == PMSC_OFF &&
    !drive_out.low_side_all)
    else $error("stop did not turn outputs off");
  a_shutoff_cuts: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (!ctrl_in.start_n && !ctrl_in.loop_comp_shutoff_pin_n)
    |=> drive_out.drive_level == 16'h0000)
    else $error("shutoff pin did not cut drive");
  a_hall_cut: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (!ctrl_in.start_n && s_q.hall_idle >= HALL_TMO)
    |=> drive_out.state != PMSC_DRIVE)
    else $error("drive with hall signals absent");
  a_noref_brake: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (!ctrl_in.start_n && ctrl_in.loop_comp_shutoff_pin_n && ext_mode &&
     s_q.hall_idle < HALL_TMO && s_q.ref_idle >= REF_TMO)
    |=> drive_out.low_side_all)
    else $error("missing reference did not brake");
  a_brake_lowside: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    drive_out.state == PMSC_BRAKE |-> drive_out.low_side_all)
    else $error("brake without low-side drive");
  a_lock_needs_ok: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    $rose(lock_detect_out) |-> $past(s_q.phase_ok))
    else $error("lock raised without phase lock");
  a_open_mask: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (ctrl_in.mask_cap_open && s_q.phase_ok &&
     s_q.drive.state == PMSC_DRIVE) |=> lock_detect_out)
    else $error("open mask pin delayed lock");
  // judge against the mask settings that were in force when lock rose
  a_mask_delay: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    ($rose(lock_detect_out) && !$past(ctrl_in.mask_cap_open)) |->
    $past(s_q.mask_cnt) >= mask_limit($past(ctrl_in.mask_cap_centi_uf)))
    else $error("lock raised before mask time");
  a_limit_hold: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (sense_at_threshold_in && s_q.drive.state == PMSC_DRIVE &&
     s_d.drive.state == PMSC_DRIVE) |=> $stable(drive_out.drive_level))
    else $error("drive rose past current limit");
endmodule

// >>> pmsc_regs.svh
// polygon motor speed control: timing counts and encodings
// assumes inclusion by bare name from package and modules
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH
// divisor encoding for {sel_b_high, sel_a}: arbitrary defaults
`define PMSC_DIV_LL 16'h0100
`define PMSC_DIV_LH 16'h0140
`define PMSC_DIV_HL 16'h01A0
`define PMSC_DIV_HH 16'h0280
// phase error window within which the loop counts as locked (cycles)
`define PMSC_LOCK_WIN 16'h0040
// mask time: 0.35 s per uF; capacitor given in units of 0.01 uF
`define PMSC_MASK_MS_PER_UF 350
`define PMSC_CLK_MHZ 100
// cycles per 0.01 uF = 0.35e-2 s * 100e6 = 350000
`define PMSC_MASK_CYC_PER_STEP (`PMSC_MASK_MS_PER_UF * `PMSC_CLK_MHZ * 10)
// hall absence guard, 40 us; a first turn slower than this is cut, so
// lengthen it for motors that start slowly
`define PMSC_HALL_TMO_US 40
`define PMSC_HALL_TMO_CYC (`PMSC_HALL_TMO_US * `PMSC_CLK_MHZ)
// external reference absence guard, same length as the hall guard
`define PMSC_REF_TMO_CYC (`PMSC_HALL_TMO_US * `PMSC_CLK_MHZ)
`define PMSC_ERR_W 16
`endif

// >>> pmsc_pkg.sv
// polygon motor speed control: shared types
// assumes pmsc_regs.svh is on the include path
package pmsc_pkg;
  `include "pmsc_regs.svh"
  // three-level decode of the second divisor pin
  typedef enum logic [1:0] {
    PMSC_LVL_LOW = 2'h0,
    PMSC_LVL_MID = 2'h1,
    PMSC_LVL_HIGH = 2'h3
  } pmsc_level_type;
  // drive state, gray coded along off -> drive -> brake
  typedef enum logic [1:0] {
    PMSC_OFF = 2'h0,
    PMSC_DRIVE = 2'h1,
    PMSC_BRAKE = 2'h3,
    PMSC_CUT = 2'h2
  } pmsc_state_type;
  // host pin-level controls
  typedef struct packed {
    logic start_n;
    logic divisor_sel_a_or_ext_ref;
    pmsc_level_type divisor_sel_b;
    logic loop_comp_shutoff_pin_n;
    logic mask_cap_open;
    logic [15:0] mask_cap_centi_uf;
  } pmsc_ctrl_type;
  // motor-side drive decision
  typedef struct packed {
    pmsc_state_type state;
    logic [15:0] drive_level;
    logic low_side_all;
    logic limit_active;
  } pmsc_drive_type;
endpackage

// >>> pmsc_ref_gen.sv
// reference pulse generator: divides crystal enable or passes ext ref
// assumes crystal_tick_in is a one-cycle enable from the crystal domain
`timescale 1ns/10ps
module pmsc_ref_gen
  import pmsc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // reference source
  input wire logic crystal_tick_in,
  input wire logic ext_mode_in,
  input wire logic ext_ref_in,
  input wire logic [15:0] divisor_in,
  // reference rising-edge pulse
  output logic ref_pulse_out
);
  typedef struct packed {
    logic [15:0] count;
    logic ext_prev;
    logic pulse;
  } pmsc_rg_state_type;
  pmsc_rg_state_type s_q, s_d;

  // crystal divide-by-N or external edge detect
  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    s_d.ext_prev = ext_ref_in;
    if (ext_mode_in) begin
      s_d.count = 16'h0000;
      s_d.pulse = ext_ref_in & ~s_q.ext_prev;
    end else if (crystal_tick_in) begin
      if (s_q.count >= divisor_in - 16'h0001) begin
        s_d.count = 16'h0000;
        s_d.pulse = 1'b1;
      end else begin
        s_d.count = s_q.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ref_pulse_out = s_q.pulse;
endmodule

// >>> pmsc_motor_model.sv
// motor model: speed feedback pulse and hall edges at a set period
// assumes period_in of at least 64 cycles, changed only between turns
`timescale 1ns/10ps
module pmsc_motor_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // turn length in cycles
  input wire logic [15:0] period_in,
  // low stops the hall edges, as with unplugged sensors
  input wire logic hall_en_in,
  // sensor outputs
  output logic fb_out,
  output logic hall_out
);
  logic [15:0] cnt_q;
  // position within one turn; rolls over at the set period
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) cnt_q <= 16'h0000;
    else if (cnt_q >= period_in - 16'h0001) cnt_q <= 16'h0000;
    else cnt_q <= cnt_q + 16'h0001;
  end
  // hall edges at every 64th count within a turn, restarting at count 0 each turn, unless switched off
  assign fb_out = (cnt_q < (period_in >> 1));
  assign hall_out = hall_en_in & (cnt_q[5:0] == 6'h00);
endmodule

// >>> tb_top.sv
// testbench: pin-level host stimulus against the speed control core
// assumes crystal enable every cycle and the header's default timings
`timescale 1ns/10ps
`include "pmsc_regs.svh"
module tb_top;
  import pmsc_pkg::*;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sense = 1'b0;
  logic ext_on = 1'b0;
  logic fb, hall, lock;
  logic hall_en = 1'b1;
  logic [15:0] perr;
  logic [15:0] per = 16'h0106;
  logic [15:0] eper = 16'h012C;
  logic [15:0] ecnt = 16'h0000;
  pmsc_ctrl_type ctrl = {1'b1, 1'b0, PMSC_LVL_LOW, 1'b1, 1'b1, 16'h0000};
  pmsc_ctrl_type ctrl_mux;
  pmsc_drive_type drv;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  // free running clock
  initial forever #5 clock_in = ~clock_in;
  // external rate reference replaces the first divisor pin
  always_comb begin
    ctrl_mux = ctrl;
    if (ext_on) ctrl_mux.divisor_sel_a_or_ext_ref = (ecnt < (eper >> 1));
  end
  // reference counter and hang guard
  always @(posedge clock_in) begin
    ecnt <= (ecnt >= eper - 16'h0001) ? 16'h0000 : ecnt + 16'h0001;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_errors++;
      final_report();
    end
  end
  pmsc_core pmsc_core_inst (
    .clock_in(clock_in), .resetn_in(resetn_in), .ctrl_in(ctrl_mux),
    .crystal_tick_in(1'b1), .speed_feedback_pulse_in(fb),
    .hall_edge_in(hall), .sense_at_threshold_in(sense),
    .drive_out(drv), .lock_detect_out(lock), .phase_error_out(perr));
  pmsc_motor_model pmsc_motor_model_inst (
    .clock_in(clock_in), .resetn_in(resetn_in), .period_in(per),
    .hall_en_in(hall_en), .fb_out(fb), .hall_out(hall));
  task automatic final_report();
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_state(input pmsc_state_type g, input pmsc_state_type e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t state %0d expected %0d", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t flag %b expected %b", $time, g, e);
    end
  endtask
  // bounded wait, sampled on the falling edge where outputs have settled
  task automatic wait_state(input pmsc_state_type e, input int lim);
    int i;
    for (i = 0; i < lim && drv.state !== e; i++) @(negedge clock_in);
    chk_state(drv.state, e);
  endtask
  task automatic t_lock();
    int i;
    @(posedge clock_in);
    ctrl.start_n <= 1'b0;
    per <= 16'h0106;
    for (i = 0; i < 20000 && lock !== 1'b1; i++) @(negedge clock_in);
    chk_bit(lock, 1'b1);
    chk_state(drv.state, PMSC_DRIVE);
    chk_bit((perr <= `PMSC_LOCK_WIN), 1'b1);
    @(posedge clock_in);
    sense <= 1'b1;
    repeat (3) @(negedge clock_in);
    chk_bit(drv.limit_active, 1'b1);
    @(posedge clock_in);
    sense <= 1'b0;
  endtask
  task automatic t_cut();
    @(posedge clock_in);
    ctrl.loop_comp_shutoff_pin_n <= 1'b0;
    repeat (3) @(negedge clock_in);
    chk_state(drv.state, PMSC_CUT);
    chk_bit((drv.drive_level == 16'h0000), 1'b1);
    chk_bit(lock, 1'b0);
    @(posedge clock_in);
    ctrl.start_n <= 1'b1;
    repeat (3) @(negedge clock_in);
    chk_state(drv.state, PMSC_OFF);
    chk_bit(drv.low_side_all, 1'b0);
    @(posedge clock_in);
    ctrl.loop_comp_shutoff_pin_n <= 1'b1;
  endtask
  // a long mask keeps lock low for the whole window
  task automatic t_mask();
    int i;
    logic seen;
    seen = 1'b0;
    @(posedge clock_in);
    ctrl.mask_cap_open <= 1'b0;
    ctrl.mask_cap_centi_uf <= 16'h0064;
    ctrl.start_n <= 1'b0;
    for (i = 0; i < 12000; i++) begin
      @(negedge clock_in);
      seen = seen | (lock === 1'b1);
    end
    chk_bit(seen, 1'b0);
    @(posedge clock_in);
    ctrl.mask_cap_open <= 1'b1;
  endtask
  // per divisor: an eighth slow does not brake over three turns once settled, an eighth fast soon does
  task automatic t_div();
    logic [15:0] dv[4] = '{`PMSC_DIV_LL, `PMSC_DIV_LH, `PMSC_DIV_HL,
                           `PMSC_DIV_HH};
    logic seen;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_in);
      ctrl.divisor_sel_b <= k[1] ? PMSC_LVL_HIGH : PMSC_LVL_LOW;
      ctrl.divisor_sel_a_or_ext_ref <= k[0];
      per <= dv[k] + (dv[k] >> 3);
      // leftover lead can last up to eight turns before lag settles
      repeat (10 * (dv[k] + (dv[k] >> 3))) @(negedge clock_in);
      seen = 1'b0;
      repeat (3 * (dv[k] + (dv[k] >> 3))) begin
        @(negedge clock_in);
        seen = seen | (drv.state === PMSC_BRAKE);
      end
      chk_bit(seen, 1'b0);
      @(posedge clock_in);
      per <= dv[k] - (dv[k] >> 3);
      wait_state(PMSC_BRAKE, 8000);
      chk_bit(drv.low_side_all, 1'b1);
    end
  endtask
  // external rate reference: slow drives, fast brakes, none brakes
  task automatic t_ext();
    @(posedge clock_in);
    ctrl.divisor_sel_b <= PMSC_LVL_MID;
    ext_on <= 1'b1;
    per <= 16'h0154;
    wait_state(PMSC_DRIVE, 8000);
    @(posedge clock_in);
    per <= 16'h0106;
    wait_state(PMSC_BRAKE, 8000);
    @(posedge clock_in);
    per <= 16'h0154;
    wait_state(PMSC_DRIVE, 8000);
    // pulses stop while the slow motor would still ask for drive
    @(posedge clock_in);
    ext_on <= 1'b0;
    wait_state(PMSC_BRAKE, `PMSC_REF_TMO_CYC + 1000);
    chk_bit(drv.low_side_all, 1'b1);
  endtask
  // a start with no hall activity must cut the output current
  task automatic t_hall();
    @(posedge clock_in);
    ctrl.divisor_sel_b <= PMSC_LVL_LOW;
    ctrl.start_n <= 1'b1;
    hall_en <= 1'b0;
    repeat (`PMSC_HALL_TMO_CYC + 100) @(negedge clock_in);
    chk_state(drv.state, PMSC_OFF);
    @(posedge clock_in);
    ctrl.start_n <= 1'b0;
    repeat (3) @(negedge clock_in);
    chk_state(drv.state, PMSC_CUT);
    chk_bit(drv.low_side_all, 1'b0);
    @(posedge clock_in);
    hall_en <= 1'b1;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(negedge clock_in);
    chk_state(drv.state, PMSC_OFF);
    t_lock();
    t_cut();
    t_mask();
    t_div();
    t_ext();
    t_hall();
    final_report();
  end
endmodule
